/* hw/srap_defs.svh */
// Constants of the serial register access port: addresses, widths, counts.
// Assumes inclusion by bare name from the package, compiled before the design modules.
`ifndef SRAP_DEFS_SVH
`define SRAP_DEFS_SVH

`define SRAP_I2C_ADDR_HI 6'h3b
`define SRAP_BYTE_W 8
`define SRAP_LAST_BIT 3'h7
`define SRAP_ADDR_MSB_SPI 1'h0
`define SRAP_BUF_DEPTH 2
`define SRAP_CLK_PERIOD_NS 50
`define SRAP_LINK_PERIOD_NS 400

`endif

/* hw/srap_pkg.sv */
// Types of the serial register access port.
// Assumes srap_defs.svh is on the include path.
`include "srap_defs.svh"

package srap_pkg;

    typedef logic [`SRAP_BYTE_W-1:0] srap_byte_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_I2C_RX = 7'h02,
        ST_I2C_ACK = 7'h04,
        ST_I2C_TX = 7'h08,
        ST_I2C_MACK = 7'h10,
        ST_I2C_WAIT = 7'h20,
        ST_SPI = 7'h40
    } srap_state_e;

    typedef enum logic [3:0] {
        PH_CTRL = 4'h1,
        PH_WDATA = 4'h2,
        PH_DUMMY = 4'h4,
        PH_RDATA = 4'h8
    } srap_phase_e;

    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] sdi_s;
        logic [1:0] sdo_s;
        logic [1:0] csb_s;
        logic sck_d;
        logic sdi_d;
        logic csb_d;
        logic spi_lock;
        srap_state_e st;
        srap_phase_e ph;
        logic mode11;
        logic seen_rise;
        logic [2:0] bitcnt;
        srap_byte_t rx;
        srap_byte_t tx;
        srap_byte_t addr;
        logic have_addr;
        logic rd_mode;
        logic addr_phase;
        logic ack_ok;
        logic sdi_out;
        logic sdi_oe;
        logic sdo_out;
        logic sdo_oe;
        logic push;
        srap_byte_t push_addr;
        srap_byte_t push_data;
    } srap_st_s;

    typedef struct packed {
        logic [`SRAP_BUF_DEPTH-1:0] full;
        srap_byte_t [`SRAP_BUF_DEPTH-1:0] addr;
        srap_byte_t [`SRAP_BUF_DEPTH-1:0] data;
    } srap_buf_s;

endpackage

/* hw/srap_wr_if.sv */
// Write stream carrier between the port engine and its two-entry buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface srap_wr_if;
    import srap_pkg::*;
    logic valid;
    logic ready;
    srap_byte_t addr;
    srap_byte_t data;
    modport src (output valid, output addr, output data, input ready);
    modport snk (input valid, input addr, input data, output ready);
endinterface

`default_nettype wire

/* hw/srap_buf.sv */
// Two-entry buffer of register writes, valid/ready on both sides.
// Assumes one clock; outputs come straight from the entry flops.
`timescale 1ns/100ps
`default_nettype none

module srap_buf (
    input wire logic mclk,
    input wire logic rst_b,
    srap_wr_if.snk in_if,
    output logic out_valid,
    input wire logic out_ready,
    output srap_pkg::srap_byte_t out_addr,
    output srap_pkg::srap_byte_t out_data
);
    import srap_pkg::*;

    srap_buf_s r;
    srap_buf_s next_r;
    logic take;
    logic give;

    assign in_if.ready = ~r.full[1];
    assign out_valid = r.full[0];
    assign out_addr = r.addr[0];
    assign out_data = r.data[0];

    always_comb begin
        next_r = r;
        take = in_if.valid & ~r.full[1];
        give = r.full[0] & out_ready;
        if (give) begin
            next_r.full = {1'b0, r.full[1]};
            next_r.addr[0] = r.addr[1];
            next_r.data[0] = r.data[1];
        end
        if (take) begin
            if (next_r.full[0]) begin
                next_r.full[1] = 1'b1;
                next_r.addr[1] = in_if.addr;
                next_r.data[1] = in_if.data;
            end else begin
                next_r.full[0] = 1'b1;
                next_r.addr[0] = in_if.addr;
                next_r.data[0] = in_if.data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule // srap_buf

`default_nettype wire

/* hw/srap_port.sv */
// Serial register access port: I2C slave and 3/4-wire SPI slave.
// Assumes mclk far faster than the serial clock (at least 8 per period),
// register file outside: rd_data answers rd_addr combinationally.
`timescale 1ns/100ps
`default_nettype none

module srap_port (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic csb_b,
    input wire logic sck,
    input wire logic sdi_in,
    output logic sdi_out,
    output logic sdi_oe,
    input wire logic sdo_in,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic three_wire_select,
    output srap_pkg::srap_byte_t rd_addr,
    input wire srap_pkg::srap_byte_t rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output srap_pkg::srap_byte_t wr_addr,
    output srap_pkg::srap_byte_t wr_data,
    output logic spi_locked
);
    import srap_pkg::*;

    srap_st_s r;
    srap_st_s next_r;
    srap_wr_if wr_if ();

    srap_buf u_buf (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_if(wr_if.snk),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_addr(wr_addr),
        .out_data(wr_data)
    );

    assign wr_if.valid = r.push;
    assign wr_if.addr = r.push_addr;
    assign wr_if.data = r.push_data;
    assign sdi_out = r.sdi_out;
    assign sdi_oe = r.sdi_oe;
    assign sdo_out = r.sdo_out;
    assign sdo_oe = r.sdo_oe;
    assign rd_addr = r.addr;
    assign spi_locked = r.spi_lock;

    function automatic srap_byte_t shift_in(input srap_byte_t v, input logic b);
        return {v[6:0], b};
    endfunction

    logic sck_v;
    logic sdi_v;
    logic csb_v;
    logic sck_rise;
    logic sck_fall;
    logic i2c_start;
    logic i2c_stop;
    logic byte_end;
    srap_byte_t rx_byte;

    always_comb begin
        next_r = r;
        sck_v = r.sck_s[1];
        sdi_v = r.sdi_s[1];
        csb_v = r.csb_s[1];
        sck_rise = sck_v & ~r.sck_d;
        sck_fall = ~sck_v & r.sck_d;
        i2c_start = sck_v & r.sck_d & r.sdi_d & ~sdi_v;
        i2c_stop = sck_v & r.sck_d & ~r.sdi_d & sdi_v;
        byte_end = r.bitcnt == `SRAP_LAST_BIT;
        rx_byte = shift_in(r.rx, sdi_v);

        next_r.sck_s = {r.sck_s[0], sck};
        next_r.sdi_s = {r.sdi_s[0], sdi_in};
        next_r.sdo_s = {r.sdo_s[0], sdo_in};
        next_r.csb_s = {r.csb_s[0], csb_b};
        next_r.sck_d = sck_v;
        next_r.sdi_d = sdi_v;
        next_r.csb_d = csb_v;
        next_r.push = 1'b0;

        if (!csb_v) begin
            next_r.spi_lock = 1'b1;
        end

        if (r.csb_d && !csb_v) begin
            // Transaction opens: sample clock level for mode
            next_r.st = ST_SPI;
            next_r.ph = PH_CTRL;
            next_r.mode11 = sck_v;
            next_r.seen_rise = 1'b0;
            next_r.bitcnt = 3'h0;
            next_r.tx = '0;
            next_r.sdi_oe = 1'b0;
            next_r.sdo_out = 1'b0;
            next_r.sdo_oe = ~three_wire_select;
        end else if (!r.csb_d && csb_v) begin
            // Deselect drops any partial byte
            next_r.st = ST_IDLE;
            next_r.bitcnt = 3'h0;
            next_r.sdi_oe = 1'b0;
            next_r.sdo_oe = 1'b0;
        end else if (r.st == ST_SPI) begin
            if (sck_rise) begin
                next_r.seen_rise = 1'b1;
                next_r.rx = rx_byte;
                next_r.bitcnt = r.bitcnt + 3'h1;
                if (byte_end) begin
                    case (r.ph)
                        PH_CTRL: begin
                            next_r.addr = {`SRAP_ADDR_MSB_SPI, rx_byte[6:0]};
                            next_r.ph = rx_byte[7] ? PH_DUMMY : PH_WDATA;
                        end
                        PH_WDATA: begin
                            next_r.push = wr_if.ready;
                            next_r.push_addr = r.addr;
                            next_r.push_data = rx_byte;
                            next_r.ph = PH_CTRL;
                        end
                        PH_DUMMY: begin
                            next_r.ph = PH_RDATA;
                        end
                        PH_RDATA: begin
                            next_r.ph = PH_RDATA;
                        end
                        default: begin
                            next_r.ph = PH_CTRL;
                        end
                    endcase
                end
            end else if (sck_fall && (r.seen_rise || !r.mode11)) begin
                // Mode 11 leading fall carries no data
                if (r.ph == PH_RDATA && r.bitcnt == 3'h0) begin
                    next_r.tx = rd_data;
                    next_r.addr = r.addr + 8'h01;
                end else begin
                    next_r.tx = {r.tx[6:0], 1'b0};
                end
                if (r.ph == PH_DUMMY || r.ph == PH_RDATA) begin
                    next_r.sdo_out = next_r.tx[7];
                    next_r.sdi_out = next_r.tx[7];
                    next_r.sdi_oe = three_wire_select;
                end
            end
        end else if (!r.spi_lock && csb_v) begin
            if (i2c_stop) begin
                next_r.st = ST_IDLE;
                next_r.sdi_oe = 1'b0;
            end else if (i2c_start) begin
                // Start or repeated start: expect slave address
                next_r.st = ST_I2C_RX;
                next_r.addr_phase = 1'b1;
                next_r.have_addr = 1'b0;
                next_r.bitcnt = 3'h0;
                next_r.sdi_oe = 1'b0;
            end else begin
                case (r.st)
                    ST_I2C_RX: begin
                        if (sck_rise) begin
                            next_r.rx = rx_byte;
                            next_r.bitcnt = r.bitcnt + 3'h1;
                            if (byte_end) begin
                                next_r.st = ST_I2C_ACK;
                                next_r.ack_ok = 1'b0;
                                if (r.addr_phase) begin
                                    // Low bit tracks the select pin live
                                    if (rx_byte[7:1] == {`SRAP_I2C_ADDR_HI, r.sdo_s[1]}) begin
                                        next_r.ack_ok = 1'b1;
                                        next_r.rd_mode = rx_byte[0];
                                    end
                                end else if (!r.have_addr) begin
                                    next_r.addr = rx_byte;
                                    next_r.have_addr = 1'b1;
                                    next_r.ack_ok = 1'b1;
                                end else if (wr_if.ready) begin
                                    next_r.push = 1'b1;
                                    next_r.push_addr = r.addr;
                                    next_r.push_data = rx_byte;
                                    next_r.have_addr = 1'b0;
                                    next_r.ack_ok = 1'b1;
                                end
                            end
                        end
                    end
                    ST_I2C_ACK: begin
                        if (sck_fall) begin
                            if (r.sdi_oe) begin
                                // Acknowledge clock done
                                next_r.sdi_oe = 1'b0;
                                next_r.bitcnt = 3'h0;
                                if (r.addr_phase && r.rd_mode) begin
                                    next_r.st = ST_I2C_TX;
                                    next_r.tx = rd_data;
                                    next_r.addr = r.addr + 8'h01;
                                    next_r.sdi_out = rd_data[7];
                                    next_r.sdi_oe = ~rd_data[7];
                                end else begin
                                    next_r.st = ST_I2C_RX;
                                end
                                next_r.addr_phase = 1'b0;
                            end else if (r.ack_ok) begin
                                next_r.sdi_out = 1'b0;
                                next_r.sdi_oe = 1'b1;
                            end else begin
                                next_r.st = ST_I2C_WAIT;
                            end
                        end
                    end
                    ST_I2C_TX: begin
                        if (sck_rise) begin
                            next_r.bitcnt = r.bitcnt + 3'h1;
                        end else if (sck_fall) begin
                            if (r.bitcnt == 3'h0) begin
                                next_r.sdi_oe = 1'b0;
                                next_r.st = ST_I2C_MACK;
                            end else begin
                                next_r.tx = {r.tx[6:0], 1'b0};
                                next_r.sdi_out = r.tx[6];
                                next_r.sdi_oe = ~r.tx[6];
                            end
                        end
                    end
                    ST_I2C_MACK: begin
                        if (sck_rise) begin
                            // Master not-acknowledge ends the burst
                            next_r.st = sdi_v ? ST_I2C_WAIT : ST_I2C_MACK;
                            next_r.ack_ok = ~sdi_v;
                        end else if (sck_fall && r.ack_ok) begin
                            next_r.st = ST_I2C_TX;
                            next_r.bitcnt = 3'h0;
                            next_r.tx = rd_data;
                            next_r.addr = r.addr + 8'h01;
                            next_r.sdi_out = rd_data[7];
                            next_r.sdi_oe = ~rd_data[7];
                            next_r.ack_ok = 1'b0;
                        end
                    end
                    ST_I2C_WAIT: begin
                        next_r.sdi_oe = 1'b0;
                    end
                    ST_IDLE: begin
                        next_r.sdi_oe = 1'b0;
                    end
                    default: begin
                        next_r.st = ST_IDLE;
                        next_r.sdi_oe = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{sck_s: 2'h3, sdi_s: 2'h3, sdo_s: 2'h0, csb_s: 2'h3,
                   sck_d: 1'b1, sdi_d: 1'b1, csb_d: 1'b1, spi_lock: 1'b0,
                   st: ST_IDLE, ph: PH_CTRL, mode11: 1'b0, seen_rise: 1'b0,
                   bitcnt: 3'h0, rx: 8'h00, tx: 8'h00, addr: 8'h00,
                   have_addr: 1'b0, rd_mode: 1'b0, addr_phase: 1'b0,
                   ack_ok: 1'b0, sdi_out: 1'b0, sdi_oe: 1'b0, sdo_out: 1'b0,
                   sdo_oe: 1'b0, push: 1'b0, push_addr: 8'h00,
                   push_data: 8'h00};
        end else begin
            r <= next_r;
        end
    end
endmodule // srap_port

`default_nettype wire

/* bench/srap_asserts.sv */
// Concurrent checks on the port pins and the write stream.
// Assumes binding into srap_port; single mclk domain.
`timescale 1ns/100ps
`default_nettype none

module srap_asserts (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic csb_b,
    input wire logic sck,
    input wire logic sdi_out,
    input wire logic sdi_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic three_wire_select,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire srap_pkg::srap_byte_t wr_addr,
    input wire srap_pkg::srap_byte_t wr_data,
    input wire logic spi_locked
);
    import srap_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    rst_quiet_a: assert property (
        $rose(rst_b) |-> !(wr_valid || spi_locked || sdi_oe || sdo_oe))
        else $error("outputs active after reset");
    lock_sticky_a: assert property (spi_locked |=> spi_locked)
        else $error("spi lock dropped");
    lock_on_select_a: assert property ($fell(csb_b) |-> ##[0:5] spi_locked)
        else $error("no lock after select");
    three_wire_sdo_a: assert property (three_wire_select [*8] |-> !sdo_oe)
        else $error("sdo driven in three wire mode");
    sdo_deselect_a: assert property (csb_b [*6] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    open_drain_a: assert property (sdi_oe && !spi_locked |-> !sdi_out)
        else $error("data line driven high in two wire mode");
    locked_idle_a: assert property ((spi_locked && csb_b) [*6] |-> !sdi_oe)
        else $error("data line driven after lock while deselected");
    wr_hold_a: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
        else $error("write word changed while stalled");
    sdo_on_fall_a: assert property (
        $changed(sdo_out) && sdo_oe && $past(sdo_oe) && !csb_b |-> !$past(sck, 2))
        else $error("sdo changed away from falling clock");

    cover property ($rose(spi_locked));
    cover property (wr_valid && !wr_ready);
    cover property (sdi_oe && !spi_locked);
    cover property (sdi_oe && spi_locked);
endmodule // srap_asserts

bind srap_port srap_asserts i_srap_asserts (.mclk(mclk), .rst_b(rst_b), .csb_b(csb_b),
    .sck(sck), .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .three_wire_select(three_wire_select), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .spi_locked(spi_locked));

`default_nettype wire

/* bench/srap_host.sv */
// Host master model: I2C and SPI transfers on a 400 ns link clock.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module srap_host (
    output logic csb_b,
    output logic sck,
    output logic h_oe,
    output logic h_val,
    input wire logic dat_line,
    input wire logic sdo_line,
    input wire logic three_w
);
    initial begin
        csb_b = 1'b1;
        sck = 1'b1;
        h_oe = 1'b0;
        h_val = 1'b1;
    end
    task automatic spi_begin(input logic m11);
        sck = m11;
        #200 csb_b = 1'b0; // Clock still across select edge
        #200;
    endtask
    task automatic spi_end(input logic m11);
        sck = m11;
        h_oe = 1'b0;
        #200 csb_b = 1'b1;
        #400;
    endtask
    task automatic spi_bits(input logic [7:0] tx, input int n, input logic drv,
        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck = 1'b0;
            #100 h_oe = drv;
            h_val = tx[i]; // MSB first
            #100 sck = 1'b1;
            #190 rx[i] = three_w ? dat_line : sdo_line;
            #10;
        end
    endtask
    task automatic i2c_start();
        // Host lets go of the data line before the clock rises
        h_oe = 1'b0;
        #200 sck = 1'b1;
        #200 h_oe = 1'b1; // Data falls while clock high
        h_val = 1'b0;
        #200 sck = 1'b0;
    endtask
    task automatic i2c_stop();
        #100 h_oe = 1'b1;
        h_val = 1'b0;
        #100 sck = 1'b1;
        #100 h_oe = 1'b0; // Data rises while clock high
        #200;
    endtask
    task automatic i2c_bit(input logic b, output logic s);
        #100 h_oe = !b; // Open drain: pull low or release
        h_val = 1'b0;
        #100 sck = 1'b1;
        #180 s = dat_line;
        #20 sck = 1'b0;
    endtask
    task automatic i2c_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        i2c_bit(!mack, ack);
    endtask
endmodule // srap_host

`default_nettype wire

/* bench/srap_port_tb.sv */
// Self-checking bench: register file, write sink model, host-driven scenarios.
// Assumes srap_host drives the link and srap_asserts is bound.
`timescale 1ns/100ps
`default_nettype none

module srap_port_tb;
    import srap_pkg::*;
    logic mclk;
    logic rst_b = 1'b0;
    logic tws = 1'b0;
    logic asel = 1'b0;
    logic stall = 1'b0;
    logic wr_ready = 1'b0;
    logic csb_b, sck, h_oe, h_val, sdi_out, sdi_oe, sdo_out, sdo_oe, wr_valid, spi_locked;
    logic dat_line, sdo_line;
    srap_byte_t rd_addr, rd_data, wr_addr, wr_data;
    logic [7:0] regs [256];
    logic [15:0] exp_q [$];
    int error_cnt = 0;
    int n_compared = 0;
    assign dat_line = (sdi_oe ? sdi_out : 1'b1) & (h_oe ? h_val : 1'b1);
    assign sdo_line = sdo_oe ? sdo_out : asel;
    assign rd_data = regs[rd_addr];

    srap_port i_srap_port (.mclk(mclk), .rst_b(rst_b), .csb_b(csb_b), .sck(sck),
        .sdi_in(dat_line), .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_in(sdo_line),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .three_wire_select(tws), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .spi_locked(spi_locked));
    srap_host i_srap_host (.csb_b(csb_b), .sck(sck), .h_oe(h_oe), .h_val(h_val),
        .dat_line(dat_line), .sdo_line(sdo_line), .three_w(tws));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        wr_ready <= #2 !stall && ($urandom_range(3) != 0);
        if (rst_b && wr_valid && wr_ready) begin
            check("wr_word", {wr_addr, wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
            regs[wr_addr] <= wr_data;
        end
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic drain();
        int n;
        n = 0;
        stall = 1'b0;
        while (exp_q.size() > 0 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        check("wr_left", 16'(exp_q.size()), 16'h0000);
        if (n == 400) results();
    endtask
    task automatic i2b(input logic [7:0] b, input logic ack);
        logic [7:0] rx;
        logic ak;
        i_srap_host.i2c_byte(b, 1'b0, rx, ak);
        check("i2c_ack", 16'(ak), 16'(!ack));
    endtask
    task automatic sb(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        i_srap_host.spi_bits(tx, 8, drv, rx);
    endtask
    task automatic spi_wr(input logic m11, input int n, input int keep);
        logic [7:0] a, d, rx;
        i_srap_host.spi_begin(m11);
        for (int k = 0; k < n; k++) begin
            a = {1'b0, 7'($urandom)};
            d = 8'($urandom);
            if (k < keep) exp_q.push_back({a, d});
            sb(a, 1'b1, rx);
            sb(d, 1'b1, rx);
        end
    endtask

    initial begin
        logic [7:0] rx, a, d;
        logic ak;
        int seed;
        seed = $urandom(32'h4bd710e1);
        for (int i = 0; i < 256; i++) regs[i] = 8'($urandom);
        repeat (6) @(posedge mclk);
        #2 rst_b = 1'b1;
        repeat (4) @(posedge mclk);
        check("lock_rst", 16'(spi_locked), 16'h0000);
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            #2 asel = s[0];
            i_srap_host.i2c_start();
            i2b({6'h3b, !asel, 1'b0}, 1'b0);
            i_srap_host.i2c_stop();
            i_srap_host.i2c_start();
            i2b({6'h3b, asel, 1'b0}, 1'b1);
            for (int k = 0; k < 2; k++) begin
                a = 8'($urandom);
                d = 8'($urandom);
                exp_q.push_back({a, d});
                i2b(a, 1'b1);
                i2b(d, 1'b1);
            end
            i_srap_host.i2c_stop();
            drain();
            i_srap_host.i2c_start();
            i2b({6'h3b, asel, 1'b0}, 1'b1);
            i2b(a, 1'b1);
            i_srap_host.i2c_start();
            i2b({6'h3b, asel, 1'b1}, 1'b1);
            for (int k = 0; k < 3; k++) begin
                i_srap_host.i2c_byte(8'hff, k < 2, rx, ak);
                check("i2c_rd", 16'(rx), 16'(regs[8'(a + k)]));
            end
            i_srap_host.i2c_stop();
        end
        spi_wr(1'b0, 2, 2);
        i_srap_host.spi_end(1'b0);
        check("lock_spi", 16'(spi_locked), 16'h0001);
        drain();
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            #2 tws = m[1];
            a = m == 3 ? 8'h7e : {1'b0, 7'($urandom)};
            i_srap_host.spi_begin(m[0]);
            sb({1'b1, a[6:0]}, 1'b1, rx);
            sb(8'($urandom), !tws, rx);
            check("spi_dummy", 16'(rx), 16'h0000);
            for (int k = 0; k < 3; k++) begin
                sb(8'($urandom), !tws, rx);
                check("spi_rd", 16'(rx), 16'(regs[8'(a + k)]));
            end
            i_srap_host.spi_end(m[0]);
        end
        @(posedge mclk);
        #2 tws = 1'b0;
        stall = 1'b1;
        spi_wr(1'b1, 3, 2);
        i_srap_host.spi_bits(8'h5a, 4, 1'b1, rx);
        i_srap_host.spi_end(1'b1);
        drain();
        @(posedge mclk);
        #2 tws = 1'b1;
        spi_wr(1'b0, 1, 1);
        i_srap_host.spi_end(1'b0);
        drain();
        i_srap_host.i2c_start();
        i2b({6'h3b, asel, 1'b0}, 1'b0);
        i_srap_host.i2c_stop();
        results();
    end
endmodule // srap_port_tb

`default_nettype wire
